// ### logic/core_swap_trim_dither_regs.sv
`timescale 1ns/1ps
`include "swap_trim_map.svh"
// Summary of operation
// RULE_01: input C and D trims are 8-bit read/write, loaded with factory trim after reset.
// RULE_02: software writes reserved bits as zero; they are not stored and read zero.
// RULE_03: software changes the overlap length only while calibration enable is low.
// RULE_04: during a swap two cores overlap for 4 plus twice overlap length cycles.
// RULE_05: at reduced core clock software may pick overlap 7, trading glitch size.
// RULE_06: output steering switches a programmed 0 to 31 cycles into each swap only.
// RULE_07: software tunes steering delay so the switch lands where both streams are valid.
// RULE_08: dither control bit 0 enables dither; reset leaves dither off.
// RULE_09: dither control bit 1 selects large dither, zero selects small.
// RULE_10: dither control bit 2 sends rounding error to DC and spurs instead of noise.
module core_swap_trim_dither_regs (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire swap_trim_pkg::axil_req_t bus_req,
  output swap_trim_pkg::axil_rsp_t bus_rsp,
  // factory trim pins, static after power-up
  input wire logic [7:0] fuse_trim_c,
  input wire logic [7:0] fuse_trim_d,
  // calibration engine
  input wire logic cal_enable,
  input wire logic swap_start,
  // converter controls
  output swap_trim_pkg::cfg_out_t cfg_out,
  output swap_trim_pkg::swap_out_t swap_out
);
  import swap_trim_pkg::*;

  state_t s_reg;
  state_t s_next;
  logic wr_fire;
  logic [6:0] overlap_cycles;

  assign overlap_cycles = `OVERLAP_BASE + {1'b0, s_reg.swap_overlap_length, 1'b0};
  assign wr_fire = s_reg.aw_have && s_reg.w_have && !s_reg.rsp.bvalid;

  always_comb begin
    s_next = s_reg;
    // fuse pins cross in through two flops before anything reads them
    s_next.fuse_s1 = {fuse_trim_c, fuse_trim_d};
    s_next.fuse_s2 = s_reg.fuse_s1;
    if (!s_reg.fuse_loaded) begin
      if (s_reg.fuse_wait == `FUSE_SETTLE) begin
        s_next.fuse_loaded = 1'b1;
        s_next.cfg.trim_c = s_reg.fuse_s2[15:8]; // RULE_01
        s_next.cfg.trim_d = s_reg.fuse_s2[7:0]; // RULE_01
      end else begin
        s_next.fuse_wait = s_reg.fuse_wait + 2'h1;
      end
    end
    // write path: address and data taken in either order, answered once both are held
    if (bus_req.awvalid && s_reg.rsp.awready) begin
      s_next.aw_have = 1'b1;
      s_next.aw_addr = bus_req.awaddr;
    end
    if (bus_req.wvalid && s_reg.rsp.wready) begin
      s_next.w_have = 1'b1;
      s_next.w_byte = bus_req.wdata[7:0];
      s_next.w_lane0 = bus_req.wstrb[0];
    end
    if (s_reg.rsp.bvalid && bus_req.bready) begin
      s_next.rsp.bvalid = 1'b0;
    end
    if (wr_fire) begin
      s_next.aw_have = 1'b0;
      s_next.w_have = 1'b0;
      s_next.rsp.bvalid = 1'b1;
      s_next.rsp.bresp = `RESP_OKAY;
      unique case (s_reg.aw_addr)
        `ADDR_OF(`IDX_TRIM_C): if (s_reg.w_lane0) s_next.cfg.trim_c = s_reg.w_byte; // RULE_01
        `ADDR_OF(`IDX_TRIM_D): if (s_reg.w_lane0) s_next.cfg.trim_d = s_reg.w_byte; // RULE_01
        `ADDR_OF(`IDX_OVERLAP): if (s_reg.w_lane0) s_next.swap_overlap_length = s_reg.w_byte[4:0];
        `ADDR_OF(`IDX_STEER): if (s_reg.w_lane0) s_next.output_steer_delay = s_reg.w_byte[4:0];
        `ADDR_OF(`IDX_DITHER): begin
          if (s_reg.w_lane0) begin
            s_next.cfg.dither_enable_bit = s_reg.w_byte[`BIT_DITH_EN]; // RULE_08
            s_next.cfg.dither_amplitude_select = s_reg.w_byte[`BIT_DITH_AMP]; // RULE_09
            s_next.cfg.dither_rounding_select = s_reg.w_byte[`BIT_DITH_ERR]; // RULE_10
          end
        end
        default: s_next.rsp.bresp = `RESP_SLVERR;
      endcase
    end
    s_next.rsp.awready = !s_next.aw_have;
    s_next.rsp.wready = !s_next.w_have;
    // read path: one read at a time, reserved bits read zero
    if (s_reg.rsp.rvalid && bus_req.rready) begin
      s_next.rsp.rvalid = 1'b0;
    end
    if (bus_req.arvalid && s_reg.rsp.arready) begin
      s_next.rsp.rvalid = 1'b1;
      s_next.rsp.rresp = `RESP_OKAY;
      s_next.rsp.rdata = 32'h0000_0000;
      unique case (bus_req.araddr)
        `ADDR_OF(`IDX_TRIM_C): s_next.rsp.rdata[7:0] = s_reg.cfg.trim_c;
        `ADDR_OF(`IDX_TRIM_D): s_next.rsp.rdata[7:0] = s_reg.cfg.trim_d;
        `ADDR_OF(`IDX_OVERLAP): s_next.rsp.rdata[4:0] = s_reg.swap_overlap_length;
        `ADDR_OF(`IDX_STEER): s_next.rsp.rdata[4:0] = s_reg.output_steer_delay;
        `ADDR_OF(`IDX_DITHER): s_next.rsp.rdata[2:0] = {s_reg.cfg.dither_rounding_select,
          s_reg.cfg.dither_amplitude_select, s_reg.cfg.dither_enable_bit};
        default: s_next.rsp.rresp = `RESP_SLVERR;
      endcase
    end
    s_next.rsp.arready = !s_next.rsp.rvalid;
    // swap sequencer: overlap window and delayed steering flip
    if (!s_reg.swap.swap_busy) begin
      if (swap_start && cal_enable) begin
        s_next.swap.swap_busy = 1'b1;
        s_next.swap.dual_sample = 1'b1; // RULE_04
        s_next.swap_cnt = 7'h01;
        if (s_reg.output_steer_delay == 5'h00) begin
          s_next.swap.steer_select = !s_reg.swap.steer_select; // RULE_06
        end
      end
    end else begin
      s_next.swap_cnt = s_reg.swap_cnt + 7'h01;
      s_next.swap.dual_sample = s_reg.swap_cnt < overlap_cycles; // RULE_04
      // steering only moves inside a swap, so a stale delay cannot disturb idle data
      if (s_reg.swap_cnt == {2'b00, s_reg.output_steer_delay}) begin
        s_next.swap.steer_select = !s_reg.swap.steer_select; // RULE_06
      end
      s_next.swap.swap_busy = (s_reg.swap_cnt < overlap_cycles) ||
        (s_reg.swap_cnt < {2'b00, s_reg.output_steer_delay});
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.rsp.awready <= 1'b1;
      s_reg.rsp.wready <= 1'b1;
      s_reg.rsp.arready <= 1'b1;
      s_reg.cfg.trim_c <= `RST_TRIM;
      s_reg.cfg.trim_d <= `RST_TRIM;
      s_reg.swap_overlap_length <= `RST_OVERLAP; // RULE_04
      s_reg.output_steer_delay <= `RST_STEER; // RULE_06
      {s_reg.cfg.dither_rounding_select, s_reg.cfg.dither_amplitude_select,
        s_reg.cfg.dither_enable_bit} <= `RST_DITHER; // RULE_08
    end else begin
      s_reg <= s_next;
    end
  end

  assign bus_rsp = s_reg.rsp;
  assign cfg_out = s_reg.cfg;
  assign swap_out = s_reg.swap;

  // helper: length of the current overlap window
  logic [7:0] dual_run;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dual_run <= 8'h00;
    end else begin
      dual_run <= s_reg.swap.dual_sample ? dual_run + 8'h01 : 8'h00;
    end
  end

  // helper: edges since the swap was taken, held apart from the sequencer's own counter
  logic [6:0] busy_run;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_run <= 7'h00;
    end else begin
      busy_run <= swap_out.swap_busy ? busy_run + 7'h01 : 7'h00;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  overlap_length_a: assert property ($fell(swap_out.dual_sample) |-> // RULE_04
    dual_run == 8'h04 + {2'b00, s_reg.swap_overlap_length, 1'b0}) else $error("overlap window length wrong");
  overlap_reset_a: assert property ($rose(aresetn) |-> // RULE_04
    s_reg.swap_overlap_length == `RST_OVERLAP && s_reg.output_steer_delay == `RST_STEER)
    else $error("swap fields reset wrong");
  overlap_write_a: assert property (wr_fire && s_reg.w_lane0 && // RULE_04
    s_reg.aw_addr == `ADDR_OF(`IDX_OVERLAP) |=> s_reg.swap_overlap_length == $past(s_reg.w_byte[4:0]))
    else $error("overlap length not written");
  // busy must last until both the window and the steering flip are done, and no longer
  swap_length_a: assert property ($fell(swap_out.swap_busy) |-> // RULE_04
    busy_run >= 7'h04 + {1'b0, s_reg.swap_overlap_length, 1'b0} &&
    busy_run >= {2'b00, s_reg.output_steer_delay} &&
    (busy_run == 7'h04 + {1'b0, s_reg.swap_overlap_length, 1'b0} ||
    busy_run == {2'b00, s_reg.output_steer_delay})) else $error("swap ended at the wrong cycle");
  steer_zero_a: assert property (!swap_out.swap_busy && swap_start && cal_enable && // RULE_06
    s_reg.output_steer_delay == 5'h00 |=> $changed(swap_out.steer_select))
    else $error("zero steer delay did not flip at start");
  steer_idle_a: assert property ($changed(swap_out.steer_select) |-> // RULE_06
    $past(swap_out.swap_busy) || $past(swap_start && cal_enable)) else $error("steering moved outside a swap");
  steer_delay_a: assert property ($changed(swap_out.steer_select) |-> // RULE_06
    busy_run == {2'b00, s_reg.output_steer_delay}) else $error("steering flipped at the wrong cycle");
  steer_write_a: assert property (wr_fire && s_reg.w_lane0 && // RULE_06
    s_reg.aw_addr == `ADDR_OF(`IDX_STEER) |=> s_reg.output_steer_delay == $past(s_reg.w_byte[4:0]))
    else $error("steer delay not written");
  trim_load_a: assert property ($rose(s_reg.fuse_loaded) |-> // RULE_01
    cfg_out.trim_c == $past(s_reg.fuse_s2[15:8]) && cfg_out.trim_d == $past(s_reg.fuse_s2[7:0]))
    else $error("factory trim not loaded");
  trim_c_write_a: assert property (wr_fire && s_reg.w_lane0 && // RULE_01
    s_reg.aw_addr == `ADDR_OF(`IDX_TRIM_C) |=> cfg_out.trim_c == $past(s_reg.w_byte))
    else $error("trim c not written");
  trim_d_write_a: assert property (wr_fire && s_reg.w_lane0 && // RULE_01
    s_reg.aw_addr == `ADDR_OF(`IDX_TRIM_D) |=> cfg_out.trim_d == $past(s_reg.w_byte))
    else $error("trim d not written");
  dither_en_a: assert property (wr_fire && s_reg.w_lane0 && // RULE_08
    s_reg.aw_addr == `ADDR_OF(`IDX_DITHER) |=> cfg_out.dither_enable_bit == $past(s_reg.w_byte[0]))
    else $error("dither enable not written");
  dither_amp_a: assert property (wr_fire && s_reg.w_lane0 && // RULE_09
    s_reg.aw_addr == `ADDR_OF(`IDX_DITHER) |=> cfg_out.dither_amplitude_select == $past(s_reg.w_byte[1]))
    else $error("dither amp not written");
  dither_err_a: assert property (wr_fire && s_reg.w_lane0 && // RULE_10
    s_reg.aw_addr == `ADDR_OF(`IDX_DITHER) |=> cfg_out.dither_rounding_select == $past(s_reg.w_byte[2]))
    else $error("dither err not written");
  dither_off_a: assert property ($rose(aresetn) |-> !cfg_out.dither_enable_bit) // RULE_08
    else $error("dither on after reset");
  write_answer_a: assert property (wr_fire |=> bus_rsp.bvalid) else $error("write not answered");
  read_answer_a: assert property (bus_req.arvalid && bus_rsp.arready |=> bus_rsp.rvalid && !bus_rsp.arready)
    else $error("read not answered");
  upper_zero_a: assert property (bus_rsp.rvalid |-> bus_rsp.rdata[31:8] == 24'h000000)
    else $error("unused read bits not zero");

  swap_seen_c: cover property ($fell(swap_out.swap_busy));
  write_seen_c: cover property (bus_rsp.bvalid && bus_req.bready);
  read_seen_c: cover property (bus_rsp.rvalid && bus_req.rready && bus_rsp.rdata != 32'h0000_0000);
  dither_on_c: cover property ($rose(cfg_out.dither_enable_bit));
  short_overlap_c: cover property (swap_out.swap_busy && s_reg.swap_overlap_length == 5'h07);
endmodule

// ### shared/swap_trim_map.svh
`ifndef SWAP_TRIM_MAP_SVH
`define SWAP_TRIM_MAP_SVH
// register indices; byte address is four times the index
`define IDX_TRIM_C 12'h080
`define IDX_TRIM_D 12'h081
`define IDX_OVERLAP 12'h09A
`define IDX_STEER 12'h09B
`define IDX_DITHER 12'h09D
`define ADDR_OF(i) ({(i), 2'b00} & 14'h3FFF)
`define RST_TRIM 8'h00
`define RST_OVERLAP 5'h08
`define RST_STEER 5'h07
`define RST_DITHER 3'h0
`define BIT_DITH_EN 0
`define BIT_DITH_AMP 1
`define BIT_DITH_ERR 2
`define OVERLAP_BASE 7'h04
`define FUSE_SETTLE 2'h2
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ### shared/swap_trim_pkg.sv
package swap_trim_pkg;
  typedef struct packed {
    logic awvalid;
    logic [13:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [13:0] araddr;
    logic rready;
  } axil_req_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;
  typedef struct packed {
    logic [7:0] trim_c;
    logic [7:0] trim_d;
    logic dither_enable_bit;
    logic dither_amplitude_select;
    logic dither_rounding_select;
  } cfg_out_t;
  typedef struct packed {
    logic swap_busy;
    logic dual_sample;
    logic steer_select;
  } swap_out_t;
  typedef struct packed {
    axil_rsp_t rsp;
    logic aw_have;
    logic w_have;
    logic [13:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane0;
    cfg_out_t cfg;
    logic [4:0] swap_overlap_length;
    logic [4:0] output_steer_delay;
    logic [1:0] fuse_wait;
    logic fuse_loaded;
    logic [15:0] fuse_s1;
    logic [15:0] fuse_s2;
    logic [6:0] swap_cnt;
    swap_out_t swap;
  } state_t;
endpackage

// ### bench/core_swap_trim_dither_regs_tb.sv
`timescale 1ns/1ps
`include "swap_trim_map.svh"
module core_swap_trim_dither_regs_tb;
  import swap_trim_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  axil_req_t bus_req = '0;
  axil_rsp_t bus_rsp;
  logic [7:0] fuse_trim_c = 8'h3C;
  logic [7:0] fuse_trim_d = 8'hC3;
  logic cal_enable = 1'b0;
  logic swap_start = 1'b0;
  cfg_out_t cfg_out;
  swap_out_t swap_out;
  int error_cnt = 0;
  int tests_run = 0;
  logic [3:0] strb = 4'hF;
  logic [1:0] resp;
  // register cases, the last an unmapped index: index, written byte, byte read back, response; reserved bits always written zero
  logic [11:0] row_idx [6] = '{`IDX_TRIM_C, `IDX_TRIM_D, `IDX_OVERLAP, `IDX_STEER, `IDX_DITHER, 12'h082};
  logic [7:0] row_wr [6] = '{8'hA5, 8'h5A, 8'h15, 8'h0A, 8'h05, 8'h33};
  logic [7:0] row_rd [6] = '{8'hA5, 8'h5A, 8'h15, 8'h0A, 8'h05, 8'h00};
  logic [1:0] row_rsp [6] = '{`RESP_OKAY, `RESP_OKAY, `RESP_OKAY, `RESP_OKAY, `RESP_OKAY, `RESP_SLVERR};

  always #2 aclk = ~aclk;

  core_swap_trim_dither_regs i_core_swap_trim_dither_regs (
    .aclk(aclk), .aresetn(aresetn), .bus_req(bus_req), .bus_rsp(bus_rsp), .fuse_trim_c(fuse_trim_c),
    .fuse_trim_d(fuse_trim_d), .cal_enable(cal_enable), .swap_start(swap_start), .cfg_out(cfg_out),
    .swap_out(swap_out));

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // trims load from the fuse pins a few edges after release, so wait before the first request
  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
  endtask

  // waits as long as the slave needs; only the watchdog ends a hung transfer
  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    bit aw;
    bit w;
    aw = 0;
    w = 0;
    bus_req.awvalid <= 1'b1;
    bus_req.awaddr <= `ADDR_OF(idx);
    bus_req.wvalid <= 1'b1;
    bus_req.wdata <= {24'h000000, d};
    bus_req.wstrb <= strb;
    bus_req.bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && bus_rsp.awready) begin
        aw = 1;
        bus_req.awvalid <= 1'b0;
      end
      if (!w && bus_rsp.wready) begin
        w = 1;
        bus_req.wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge aclk);
    end while (!bus_rsp.bvalid);
    resp = bus_rsp.bresp;
    bus_req.bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [11:0] idx, input logic [7:0] exp, input logic [1:0] exp_rsp);
    bus_req.arvalid <= 1'b1;
    bus_req.araddr <= `ADDR_OF(idx);
    bus_req.rready <= 1'b1;
    do begin
      @(posedge aclk);
    end while (!bus_rsp.arready);
    bus_req.arvalid <= 1'b0;
    do begin
      @(posedge aclk);
    end while (!bus_rsp.rvalid);
    chk($sformatf("read data %h", idx), {24'h000000, exp}, bus_rsp.rdata);
    chk($sformatf("read resp %h", idx), exp_rsp, bus_rsp.rresp);
    bus_req.rready <= 1'b0;
    @(posedge aclk);
  endtask

  // overlap is only rewritten with calibration disabled; outputs sampled 1 ns after each edge
  task automatic swap(input logic [7:0] ov, input logic [7:0] dly);
    int n;
    int t;
    logic s0;
    n = 0;
    t = -1;
    wr(`IDX_OVERLAP, ov);
    wr(`IDX_STEER, dly);
    cal_enable <= 1'b1;
    swap_start <= 1'b1;
    s0 = swap_out.steer_select;
    @(posedge aclk);
    swap_start <= 1'b0;
    for (int k = 0; k < 200; k++) begin
      #1;
      if (swap_out.dual_sample === 1'b1) n++;
      if (t < 0 && swap_out.steer_select !== s0) t = k;
      if (swap_out.swap_busy !== 1'b1) break;
      @(posedge aclk);
    end
    chk("overlap cycles", 4 + 2 * ov, n);
    chk("steer delay", dly, t);
    @(posedge aclk);
    cal_enable <= 1'b0;
    @(posedge aclk);
  endtask

  initial begin
    do_reset();
    chk("fuse trim c", 8'h3C, cfg_out.trim_c);
    rd(`IDX_TRIM_D, 8'hC3, `RESP_OKAY);
    rd(`IDX_OVERLAP, `RST_OVERLAP, `RESP_OKAY);
    rd(`IDX_STEER, `RST_STEER, `RESP_OKAY);
    rd(`IDX_DITHER, `RST_DITHER, `RESP_OKAY);
    for (int i = 0; i < 6; i++) begin
      wr(row_idx[i], row_wr[i]);
      chk("write resp", row_rsp[i], resp);
      rd(row_idx[i], row_rd[i], row_rsp[i]);
    end
    chk("trim outputs", 16'hA55A, {cfg_out.trim_c, cfg_out.trim_d});
    // a write with no byte lane enabled must leave the trim alone
    strb = 4'h0;
    wr(`IDX_TRIM_C, 8'h11);
    strb = 4'hF;
    rd(`IDX_TRIM_C, 8'hA5, `RESP_OKAY);
    for (int b = 0; b < 3; b++) begin
      wr(`IDX_DITHER, 8'h01 << b);
      chk("dither bits", 3'h1 << b, {cfg_out.dither_rounding_select,
        cfg_out.dither_amplitude_select, cfg_out.dither_enable_bit});
    end
    // start request with calibration disabled is ignored
    swap_start <= 1'b1;
    @(posedge aclk);
    swap_start <= 1'b0;
    #1;
    chk("swap refused", 1'b0, swap_out.swap_busy);
    @(posedge aclk);
    swap(8'h00, 8'h02);
    swap(8'h07, 8'h00);
    swap(8'h1F, 8'h1F);
    do_reset();
    rd(`IDX_OVERLAP, `RST_OVERLAP, `RESP_OKAY);
    rd(`IDX_TRIM_C, 8'h3C, `RESP_OKAY);
    rd(`IDX_DITHER, `RST_DITHER, `RESP_OKAY);
    conclude();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    conclude();
  end
endmodule
